/* hdl/pblc_pkg.sv */
// Package: constants and types for the power button and indicator controller
package pblc_pkg;
    // Register map (offset 0x317 is not a multiple of four: index, byte address = 4*index)
    localparam logic [11:0] PBLC_IDX_USER_IND  = 12'h317;
    localparam logic [13:0] PBLC_ADDR_USER_IND = 14'(PBLC_IDX_USER_IND) << 2;
    localparam logic [13:0] PBLC_ADDR_CONFIG   = 14'h0000;
    localparam logic [13:0] PBLC_ADDR_STATUS   = 14'h0004;
    localparam logic [13:0] PBLC_ADDR_BOOT     = 14'h0008;
    // Field positions
    localparam int PBLC_UI_GREEN_BIT = 0;
    localparam int PBLC_UI_RED_BIT   = 1;
    localparam int PBLC_BOOT_FW_BIT  = 0;
    localparam int PBLC_BOOT_HO_BIT  = 1;
    // Reset values
    localparam logic [7:0] PBLC_USER_IND_RST = 8'h00;
    localparam logic [1:0] PBLC_SLEEP_SEL_RST = 2'h0;
    // Timing
    localparam longint PBLC_CLK_HZ        = 250000000;
    localparam longint PBLC_DEBOUNCE_MS   = 10;
    localparam longint PBLC_HOLD_MS       = 4000;
    localparam longint PBLC_RESET_PULSE_US = 100;
    localparam longint PBLC_FAST_HZ       = 8;
    localparam longint PBLC_SLOW_HZ       = 1;
    localparam longint PBLC_DEBOUNCE_CYC  = PBLC_CLK_HZ / 1000 * PBLC_DEBOUNCE_MS;
    localparam longint PBLC_HOLD_CYC      = PBLC_CLK_HZ / 1000 * PBLC_HOLD_MS + 1;
    localparam longint PBLC_RESET_CYC     = PBLC_CLK_HZ / 1000000 * PBLC_RESET_PULSE_US;
    localparam longint PBLC_FAST_HALF_CYC = PBLC_CLK_HZ / (2 * PBLC_FAST_HZ);
    localparam longint PBLC_SLOW_HALF_CYC = PBLC_CLK_HZ / (2 * PBLC_SLOW_HZ);
    // Sleep target selection codes
    localparam logic [1:0] PBLC_SEL_S1 = 2'h0;
    localparam logic [1:0] PBLC_SEL_S3 = 2'h1;
    // Power states, one-hot
    typedef enum logic [3:0] {
        PBLC_S0 = 4'h1,
        PBLC_S1 = 4'h2,
        PBLC_S3 = 4'h4,
        PBLC_S5 = 4'h8
    } pblc_pstate_t;
    // Indicator outputs grouped together
    typedef struct packed {
        logic diagGreen;
        logic diskRed;
        logic userGreen;
        logic userRed;
    } pblc_leds_t;
endpackage

/* hdl/pblc_power_led_ctrl.sv */
// Module: power button state machine, reset button, indicators and AHB-Lite registers
// Summary of operation
// - A power press in soft-off moves the system to full-on.
// - A power press in full-on enters S1, S3 or S5 per configuration when the button is released.
// - Power button held over four seconds in full-on forces soft-off.
// - Presses are detected from edges of momentary button levels.
// - A reset press asserts a system reset pulse and clears the software registers.
// - Green diagnostic light blinks near 8 Hz until firmware starts.
// - Then blinks near 1 Hz until handoff, then stays lit.
// - Red status light is on while any disk access is active.
// - Software switches user lights through the user indicator register.
// - Bit 0 green, bit 1 red, upper bits reserved, reset clears it.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pblc_power_led_ctrl #(
    parameter longint DEBOUNCE_CYC  = pblc_pkg::PBLC_DEBOUNCE_CYC,
    parameter longint HOLD_CYC      = pblc_pkg::PBLC_HOLD_CYC,
    parameter longint RESET_CYC     = pblc_pkg::PBLC_RESET_CYC,
    parameter longint FAST_HALF_CYC = pblc_pkg::PBLC_FAST_HALF_CYC,
    parameter longint SLOW_HALF_CYC = pblc_pkg::PBLC_SLOW_HALF_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 powerButtonInput,
    input  wire logic                 resetButtonInput,
    input  wire logic                 diskActive,
    output pblc_pkg::pblc_pstate_t    powerState,
    output logic                      sysResetN,
    output pblc_pkg::pblc_leds_t      leds
);
    import pblc_pkg::*;

    // Counter width covers the longest count
    localparam int CW = 32;

    // Debounce: settle count per button, stable level stored
    function automatic logic [CW-1:0] bumpCount(input logic [CW-1:0] c, input logic differ);
        bumpCount = differ ? c + 32'h00000001 : 32'h00000000;
    endfunction

    logic [CW-1:0] pwrDbCnt_reg;
    logic [CW-1:0] rstDbCnt_reg;
    logic          pwrStable_reg;
    logic          rstStable_reg;
    wire           pwrDiffer = powerButtonInput != pwrStable_reg;
    wire           rstDiffer = resetButtonInput != rstStable_reg;
    wire           pwrSettle = pwrDiffer && (pwrDbCnt_reg >= CW'(DEBOUNCE_CYC - 1));
    wire           rstSettle = rstDiffer && (rstDbCnt_reg >= CW'(DEBOUNCE_CYC - 1));
    wire           pwrPress  = pwrSettle && powerButtonInput;
    wire           pwrRelease = pwrSettle && !powerButtonInput;
    wire           rstPress  = rstSettle && resetButtonInput;

    // Debounce registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwrDbCnt_reg  <= '0;
            rstDbCnt_reg  <= '0;
            pwrStable_reg <= 1'b0;
            rstStable_reg <= 1'b0;
        end else begin
            pwrDbCnt_reg  <= pwrSettle ? '0 : bumpCount(pwrDbCnt_reg, pwrDiffer);
            rstDbCnt_reg  <= rstSettle ? '0 : bumpCount(rstDbCnt_reg, rstDiffer);
            if (pwrSettle) pwrStable_reg <= powerButtonInput;
            if (rstSettle) rstStable_reg <= resetButtonInput;
        end
    end

    // Registers written by software
    logic [7:0]   userInd_reg;
    logic [1:0]   sleepSel_reg;
    logic [1:0]   boot_reg;
    // Hold timer and one-shot flag
    logic [CW-1:0] holdCnt_reg;
    logic          holdDone_reg;
    // Release acts only when its press was taken in full-on, so a wake press never sleeps again
    logic          relArm_reg;
    pblc_pstate_t  state_reg;
    pblc_pstate_t  state_next;
    wire           holdExpire = pwrStable_reg && !holdDone_reg && state_reg == PBLC_S0
                                && holdCnt_reg >= CW'(HOLD_CYC - 1);

    // Sleep target from configuration
    wire pblc_pstate_t sleepTarget = (sleepSel_reg == PBLC_SEL_S1) ? PBLC_S1 :
                                     (sleepSel_reg == PBLC_SEL_S3) ? PBLC_S3 : PBLC_S5;

    // Power state transitions
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PBLC_S0: begin
                if (holdExpire) state_next = PBLC_S5;
                else if (pwrRelease && relArm_reg && !holdDone_reg) state_next = sleepTarget;
            end
            PBLC_S5: begin
                if (pwrPress) state_next = PBLC_S0;
            end
            PBLC_S1, PBLC_S3: begin
                if (pwrPress) state_next = PBLC_S0;
            end
            default: state_next = PBLC_S5;
        endcase
    end

    // Power state and hold timer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg    <= PBLC_S5;
            holdCnt_reg  <= '0;
            holdDone_reg <= 1'b0;
            relArm_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            holdCnt_reg  <= (pwrStable_reg && state_reg == PBLC_S0) ? holdCnt_reg + 32'h00000001 : '0;
            if (pwrPress) holdDone_reg <= 1'b0;
            else if (holdExpire) holdDone_reg <= 1'b1;
            if (pwrPress) relArm_reg <= state_reg == PBLC_S0;
        end
    end

    // Reset pulse generator; reset button also clears the software registers
    logic [CW-1:0] rstPulseCnt_reg;
    logic          sysResetN_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rstPulseCnt_reg <= '0;
            sysResetN_reg   <= 1'b0;
        end else if (rstPress) begin
            rstPulseCnt_reg <= CW'(RESET_CYC);
            sysResetN_reg   <= 1'b0;
        end else if (rstPulseCnt_reg != '0) begin
            rstPulseCnt_reg <= rstPulseCnt_reg - 32'h00000001;
            sysResetN_reg   <= 1'b0;
        end else begin
            sysResetN_reg   <= 1'b1;
        end
    end
    // Partial restart: only the software registers also clear on a reset press
    wire softClear = !nrst || rstPress;

    // Blink dividers
    logic [CW-1:0] fastCnt_reg;
    logic [CW-1:0] slowCnt_reg;
    logic          fastBlink_reg;
    logic          slowBlink_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fastCnt_reg   <= '0;
            slowCnt_reg   <= '0;
            fastBlink_reg <= 1'b0;
            slowBlink_reg <= 1'b0;
        end else begin
            fastCnt_reg <= (fastCnt_reg >= CW'(FAST_HALF_CYC - 1)) ? '0 : fastCnt_reg + 32'h00000001;
            slowCnt_reg <= (slowCnt_reg >= CW'(SLOW_HALF_CYC - 1)) ? '0 : slowCnt_reg + 32'h00000001;
            if (fastCnt_reg >= CW'(FAST_HALF_CYC - 1)) fastBlink_reg <= !fastBlink_reg;
            if (slowCnt_reg >= CW'(SLOW_HALF_CYC - 1)) slowBlink_reg <= !slowBlink_reg;
        end
    end

    // Diagnostic green select by boot progress
    wire diagNext = boot_reg[PBLC_BOOT_HO_BIT] ? 1'b1 :
                    boot_reg[PBLC_BOOT_FW_BIT] ? slowBlink_reg :
                    fastBlink_reg;
    // Diagnostic light moves only on fast divider ticks, so a rate switch never makes a short pulse
    // Slow half period is a multiple of the fast one, so slow toggles fall on these ticks too
    wire fastTick = fastCnt_reg >= CW'(FAST_HALF_CYC - 1);

    // AHB-Lite address phase capture
    logic        wrPend_reg;
    logic [13:0] dAddr_reg;
    wire         addrValid = hsel && htrans[1] && hready;
    wire         selUser   = dAddr_reg == PBLC_ADDR_USER_IND;
    wire         selConfig = dAddr_reg == PBLC_ADDR_CONFIG;
    wire         selBoot   = dAddr_reg == PBLC_ADDR_BOOT;
    wire         aUser     = haddr[13:0] == PBLC_ADDR_USER_IND && haddr[31:14] == '0;
    wire         aConfig   = haddr[13:0] == PBLC_ADDR_CONFIG && haddr[31:14] == '0;
    wire         aStatus   = haddr[13:0] == PBLC_ADDR_STATUS && haddr[31:14] == '0;
    wire         aBoot     = haddr[13:0] == PBLC_ADDR_BOOT && haddr[31:14] == '0;

    // Read data for the address presented; unmapped reads return zero
    logic [31:0] rdNext;
    assign rdNext = aUser   ? {24'h000000, userInd_reg} :
                    aConfig ? {30'h00000000, sleepSel_reg} :
                    aStatus ? {28'h0000000, state_reg} :
                    aBoot   ? {30'h00000000, boot_reg} : 32'h00000000;

    // Bus phase registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wrPend_reg <= 1'b0;
            dAddr_reg  <= '0;
            hrdata     <= '0;
        end else begin
            wrPend_reg <= addrValid && hwrite;
            if (addrValid) dAddr_reg <= haddr[13:0];
            if (addrValid && !hwrite) hrdata <= rdNext;
        end
    end

    // Register writes in the data phase
    always_ff @(posedge clk) begin
        if (softClear) begin
            userInd_reg  <= PBLC_USER_IND_RST;
            sleepSel_reg <= PBLC_SLEEP_SEL_RST;
            boot_reg     <= '0;
        end else if (wrPend_reg) begin
            if (selUser) userInd_reg <= {6'h00, hwdata[1:0]};
            if (selConfig) sleepSel_reg <= hwdata[1:0];
            if (selBoot) boot_reg <= hwdata[1:0];
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            powerState <= PBLC_S5;
            sysResetN  <= 1'b0;
            leds       <= '0;
        end else begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            powerState <= state_next;
            sysResetN  <= sysResetN_reg;
            if (fastTick) leds.diagGreen <= diagNext;
            leds.diskRed   <= diskActive;
            leds.userGreen <= userInd_reg[PBLC_UI_GREEN_BIT];
            leds.userRed   <= userInd_reg[PBLC_UI_RED_BIT];
        end
    end
endmodule // pblc_power_led_ctrl

/* dv/pblc_checker.sv */
// Checker: assertions on the controller's ports
`timescale 1ns/1ps
module pblc_checker #(
    parameter longint DEBOUNCE_CYC = 4,
    parameter longint HOLD_CYC     = 50
) (
    input wire logic                   clk,
    input wire logic                   nrst,
    input wire logic                   hsel,
    input wire logic            [31:0] haddr,
    input wire logic            [1:0]  htrans,
    input wire logic                   hwrite,
    input wire logic            [31:0] hwdata,
    input wire logic                   hready,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic                   powerButtonInput,
    input wire logic                   diskActive,
    input wire pblc_pkg::pblc_pstate_t powerState,
    input wire logic                   sysResetN,
    input wire pblc_pkg::pblc_leds_t   leds
);
    import pblc_pkg::*;
    longint    holdCnt;
    wire logic wrUser = hsel && htrans[1] && hready && hwrite && haddr == 32'(PBLC_ADDR_USER_IND);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Consecutive cycles with the power button down
    always_ff @(posedge clk) begin
        holdCnt <= powerButtonInput ? holdCnt + 1 : 0;
    end
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_disk_follow: assert property ($past(nrst) |-> leds.diskRed == $past(diskActive))
        else $error("disk light does not follow activity");
    a_state_onehot: assert property ($onehot(powerState))
        else $error("power state not one-hot");
    a_wake_held: assert property ($past(powerState) != PBLC_S0 && powerState == PBLC_S0 |->
        $past(powerButtonInput) && $past(powerButtonInput, 4)) else $error("wake without debounced press");
    a_user_leds: assert property (wrUser |=> ##2
        {leds.userRed, leds.userGreen} == $past(hwdata[1:0], 2)) else $error("user lights miss write");
    a_diag_hold: assert property ($changed(leds.diagGreen) |=> $stable(leds.diagGreen) [*3])
        else $error("diagnostic light toggles too fast");
    a_reset_pulse: assert property ($fell(sysResetN) |-> !sysResetN [*6] ##1 sysResetN)
        else $error("system reset pulse length wrong");
    a_long_hold: assert property (powerState == PBLC_S0 && holdCnt == DEBOUNCE_CYC + HOLD_CYC - 1 |->
        ##[0:4] powerState == PBLC_S5) else $error("long hold did not force soft-off");
endmodule // pblc_checker

bind pblc_power_led_ctrl pblc_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .HOLD_CYC(HOLD_CYC)) u_pblc_checker (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .powerButtonInput(powerButtonInput), .diskActive(diskActive), .powerState(powerState),
    .sysResetN(sysResetN), .leds(leds)
);

/* dv/pblc_button_model.sv */
// Partner model: momentary power and reset buttons with contact bounce
`timescale 1ns/1ps
module pblc_button_model (
    input  wire logic clk,
    output logic      powerButtonInput,
    output logic      resetButtonInput
);
    // Released contacts read low, nothing latches
    initial begin
        powerButtonInput = 1'b0;
        resetButtonInput = 1'b0;
    end
    // Bounce two cycles, settle, hold, then let go
    task automatic push(input logic which, input int cycles);
        for (int i = 0; i < cycles + 4; i++) begin
            if (which) resetButtonInput <= (i < 2 || i >= 4);
            else powerButtonInput <= (i < 2 || i >= 4);
            @(posedge clk);
        end
        if (which) resetButtonInput <= 1'b0;
        else powerButtonInput <= 1'b0;
        // Stay released until the release has settled through the debouncer
        repeat (8) @(posedge clk);
    endtask
endmodule // pblc_button_model

/* dv/testbench.sv */
// Testbench: register, button and indicator tests
`timescale 1ns/1ps
module testbench;
    import pblc_pkg::*;
    logic         clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, diskActive = 1'b0, sawRst = 1'b0;
    logic  [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic  [1:0]  htrans = 2'h0;
    logic  [2:0]  hsize = 3'h2;
    logic         hreadyout, hresp, powerButtonInput, resetButtonInput, sysResetN;
    pblc_pstate_t powerState;
    pblc_leds_t   leds;
    int           error_cnt = 0, samples_checked = 0, cycles = 0, t;
    logic  [31:0] uv [4] = '{32'hFF, 32'h2, 32'h1, 32'hFC};
    pblc_pstate_t sel [4] = '{PBLC_S1, PBLC_S3, PBLC_S5, PBLC_S5};
    pblc_power_led_ctrl #(.DEBOUNCE_CYC(4), .HOLD_CYC(50), .RESET_CYC(5), .FAST_HALF_CYC(4), .SLOW_HALF_CYC(16))
    u_pblc_power_led_ctrl (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .powerButtonInput(powerButtonInput), .resetButtonInput(resetButtonInput), .diskActive(diskActive),
        .powerState(powerState), .sysResetN(sysResetN), .leds(leds));
    pblc_button_model u_pblc_button_model (.clk(clk), .powerButtonInput(powerButtonInput),
        .resetButtonInput(resetButtonInput));
    // Clock, hang limit and reset pulse watch
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (nrst && sysResetN === 1'b0) sawRst <= 1'b1;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("Errors %0d, comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One AHB-Lite single transfer, read data lands in rd
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= 32'(a);
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_state(input pblc_pstate_t s);
        for (int i = 0; i < 200 && powerState !== s; i++) @(posedge clk);
        check(32'(powerState), 32'(s));
    endtask
    // Count diagnostic light toggles over n cycles
    task automatic toggles(input int n);
        logic p;
        t = 0;
        p = leds.diagGreen;
        repeat (n) begin
            @(negedge clk);
            if (leds.diagGreen !== p) t++;
            p = leds.diagGreen;
        end
        @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(0, PBLC_ADDR_USER_IND, 0);
        check(rd, 32'(PBLC_USER_IND_RST));
        bus(0, PBLC_ADDR_STATUS, 0);
        check(rd, 32'(PBLC_S5));
        toggles(64);
        check(32'(t >= 15 && t <= 17), 1);
        foreach (uv[i]) begin
            bus(1, PBLC_ADDR_USER_IND, uv[i]);
            bus(0, PBLC_ADDR_USER_IND, 0);
            check(rd, uv[i] & 32'h3);
            @(negedge clk);
            check({leds.userRed, leds.userGreen}, uv[i] & 32'h3);
            @(posedge clk);
        end
        bus(1, 14'h0100, 32'hFFFF_FFFF);
        bus(0, 14'h0100, 0);
        check(rd, 0);
        for (int v = 1; v >= 0; v--) begin
            diskActive <= 1'(v);
            @(posedge clk);
            @(negedge clk);
            check(leds.diskRed, 32'(v));
            @(posedge clk);
        end
        u_pblc_button_model.push(1'b0, 10);
        wait_state(PBLC_S0);
        u_pblc_button_model.push(1'b0, 0);
        repeat (20) @(posedge clk);
        check(32'(powerState), 32'(PBLC_S0));
        for (int c = 0; c < 4; c++) begin
            bus(1, PBLC_ADDR_CONFIG, 32'(c));
            u_pblc_button_model.push(1'b0, 10);
            wait_state(sel[c]);
            u_pblc_button_model.push(1'b0, 10);
            wait_state(PBLC_S0);
        end
        u_pblc_button_model.push(1'b0, 80);
        repeat (20) @(posedge clk);
        check(32'(powerState), 32'(PBLC_S5));
        bus(1, PBLC_ADDR_BOOT, 1);
        toggles(128);
        check(32'(t >= 7 && t <= 9), 1);
        bus(1, PBLC_ADDR_BOOT, 3);
        repeat (4) @(posedge clk);
        toggles(64);
        check({t[30:0], leds.diagGreen}, 1);
        bus(1, PBLC_ADDR_USER_IND, 3);
        sawRst = 1'b0;
        u_pblc_button_model.push(1'b1, 10);
        repeat (20) @(posedge clk);
        check(sawRst, 1);
        bus(0, PBLC_ADDR_USER_IND, 0);
        check(rd, 0);
        give_verdict();
    end
endmodule // testbench
